// file: design/i2c_master_scl_timing.sv
// Purpose: i2c master bit engine with programmable scl phase timing, axi4-lite registers
// Assumes: clk is the system clock all phases are counted in; pins are open-drain
// Notes:   commands are queued one deep; timing counts are latched at each start
// What this block does
// - scl high lasts high count plus five
// - scl low lasts low count plus two
// - start hold lasts setup count plus one
// - repeated start setup lasts setup count plus one
// - stop setup keeps scl high count plus five
// - bus free is half high plus extra plus two
// - all intervals counted in 16 ns system clocks
// - boot at 100 kHz, reprogrammable up to 400 kHz
// - scl period is high plus low counts plus seven, plus the held cycles
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`include "i2c_timing_cfg.svh"
module i2c_master_scl_timing #(
    parameter int CW = 16                       // width of each count register
) (
    input  wire logic          clk,             // system clock
    input  wire logic          reset,           // synchronous, active high
    input  wire logic [7:0]    s_axi_awaddr,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    output logic [1:0]         s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    input  wire logic [7:0]    s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready,
    input  wire logic          sda_in,          // sda line level
    output logic               scl_oe,          // high pulls scl low
    output logic               sda_oe           // high pulls sda low
);
    // all state of the block
    typedef struct packed {
        i2c_timing_pkg::phase_t phase;           // current bus phase
        logic [CW:0]            cnt;             // cycles spent in phase
        logic [CW-1:0]          high, low, hold_setup, free_extra; // software counts
        logic [CW-1:0]          sh_high, sh_low, sh_hold_setup, sh_free_extra; // latched copies
        i2c_timing_pkg::cmd_t   cmd;             // queued command
        logic                   cmd_bit, rx_bit, err; // queued data bit, sampled bit, refusal
        logic                   scl_oe, sda_oe, aw_hold, w_hold; // pin drives, held halves
        logic [7:0]             awaddr;
        logic [31:0]            wdata;
        logic [3:0]             wstrb;
        logic                   awready, wready, bvalid, arready, rvalid;
        logic [1:0]             bresp, rresp;
        logic [31:0]            rdata;
    } state_t;
    state_t      r, n;                           // registered and next state
    logic [CW:0] lim;                            // length of current phase
    logic        done;                           // last cycle of phase
    // byte-lane merge of a count register
    function automatic logic [CW-1:0] merge(input logic [CW-1:0] old,
                                            input logic [31:0] d, input logic [3:0] s);
        logic [31:0] t;
        t = 32'(old);
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                t[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return t[CW-1:0];
    endfunction
    // phase length from latched counts, in system clock cycles
    always_comb begin
        unique case (r.phase)
            i2c_timing_pkg::HIGH, i2c_timing_pkg::STOP_SETUP:
                lim = {1'b0, r.sh_high} + `ADD_HIGH;
            i2c_timing_pkg::LOW, i2c_timing_pkg::RS_LOW, i2c_timing_pkg::STOP_LOW:
                lim = {1'b0, r.sh_low} + `ADD_LOW;
            i2c_timing_pkg::START_SETUP, i2c_timing_pkg::START_HOLD:
                lim = {1'b0, r.sh_hold_setup} + `ADD_SETUP;
            i2c_timing_pkg::BUS_FREE:
                lim = {2'b00, r.sh_high[CW-1:1]} + {1'b0, r.sh_free_extra} + `ADD_FREE;
            default:
                lim = {(CW+1){1'b1}};                                // untimed phases
        endcase
        done = (r.cnt == lim - {{CW{1'b0}}, 1'b1});
    end
    // next state: bus slave, command queue and phase sequencer
    always_comb begin
        n = r;
        if (s_axi_awvalid && r.awready) begin // address and data taken in either order
            n.aw_hold = 1'b1;
            n.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && r.wready) begin
            n.w_hold = 1'b1;
            n.wdata  = s_axi_wdata;
            n.wstrb  = s_axi_wstrb;
        end
        if (r.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        if (r.aw_hold && r.w_hold && !r.bvalid) begin // write once both halves are held
            n.aw_hold = 1'b0;
            n.w_hold  = 1'b0;
            n.bvalid  = 1'b1;
            n.bresp   = `RESP_OKAY;
            unique case (r.awaddr)
                `OFF_CMD: begin
                    if (r.wstrb[0] || r.wstrb[1]) begin
                        if (r.cmd != i2c_timing_pkg::CMD_NONE) begin // queue full: refuse
                            n.err = 1'b1;
                        end else begin
                            n.cmd     = i2c_timing_pkg::cmd_t'(r.wdata[`CMD_MSB:`CMD_LSB]);
                            n.cmd_bit = r.wdata[`CMD_BIT_POS];
                        end
                    end
                end
                `OFF_STATUS: begin
                    if (r.wstrb[0] && r.wdata[`ST_ERR_POS]) begin
                        n.err = 1'b0;                 // write one to clear
                    end
                end
                `OFF_HIGH: n.high = merge(r.high, r.wdata, r.wstrb);
                `OFF_LOW:  n.low  = merge(r.low,  r.wdata, r.wstrb);
                `OFF_SETUP: n.hold_setup = merge(r.hold_setup, r.wdata, r.wstrb);
                `OFF_FREE:  n.free_extra = merge(r.free_extra, r.wdata, r.wstrb);
                default:   n.bresp = `RESP_SLVERR;
            endcase
        end
        if (r.rvalid && s_axi_rready) begin // read channel
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid && r.arready) begin
            n.rvalid = 1'b1;
            n.rresp  = `RESP_OKAY;
            n.rdata  = 32'h00000000;
            unique case (s_axi_araddr)
                `OFF_CMD: begin
                    n.rdata[`CMD_MSB:`CMD_LSB] = r.cmd;
                    n.rdata[`CMD_BIT_POS]      = r.cmd_bit;
                end
                `OFF_STATUS: begin
                    n.rdata[`ST_BUSY_POS] = (r.phase != i2c_timing_pkg::IDLE)
                                         && (r.phase != i2c_timing_pkg::HOLD);
                    n.rdata[`ST_RX_POS]   = r.rx_bit;
                    n.rdata[`ST_HELD_POS] = (r.phase == i2c_timing_pkg::HOLD);
                    n.rdata[`ST_ERR_POS]  = r.err;
                    n.rdata[`ST_PEND_POS] = (r.cmd != i2c_timing_pkg::CMD_NONE);
                end
                `OFF_HIGH: n.rdata[CW-1:0] = r.high;
                `OFF_LOW:  n.rdata[CW-1:0] = r.low;
                `OFF_SETUP: n.rdata[CW-1:0] = r.hold_setup;
                `OFF_FREE:  n.rdata[CW-1:0] = r.free_extra;
                default:   n.rresp = `RESP_SLVERR;
            endcase
        end
        n.cnt = r.cnt + {{CW{1'b0}}, 1'b1}; // phase sequencer counts every cycle of a timed phase; idle and hold keep it at zero
        unique case (r.phase)
            i2c_timing_pkg::IDLE: begin
                n.cnt = '0;
                if (r.cmd == i2c_timing_pkg::CMD_START) begin
                    n.cmd     = i2c_timing_pkg::CMD_NONE;
                    n.sh_high = r.high;
                    n.sh_low  = r.low;
                    n.sh_hold_setup = r.hold_setup;
                    n.sh_free_extra = r.free_extra;
                    n.sda_oe  = 1'b1;                 // start: sda falls, scl high
                    n.phase   = i2c_timing_pkg::START_HOLD;
                end else if (r.cmd != i2c_timing_pkg::CMD_NONE) begin
                    n.cmd = i2c_timing_pkg::CMD_NONE; // no bus owned: refuse
                    n.err = 1'b1;
                end
            end
            i2c_timing_pkg::HOLD: begin
                n.cnt = '0;
                unique case (r.cmd)
                    i2c_timing_pkg::CMD_WRITE, i2c_timing_pkg::CMD_READ: begin
                        n.sda_oe = (r.cmd == i2c_timing_pkg::CMD_WRITE) & ~r.cmd_bit;
                        n.phase  = i2c_timing_pkg::LOW;
                    end
                    i2c_timing_pkg::CMD_STOP: begin
                        n.sda_oe = 1'b1;
                        n.phase  = i2c_timing_pkg::STOP_LOW;
                    end
                    i2c_timing_pkg::CMD_START: begin
                        n.sh_high = r.high;
                        n.sh_low  = r.low;
                        n.sh_hold_setup = r.hold_setup;
                        n.sh_free_extra = r.free_extra;
                        n.sda_oe  = 1'b0;
                        n.phase   = i2c_timing_pkg::RS_LOW;
                    end
                    default: ;
                endcase
                if (r.cmd != i2c_timing_pkg::CMD_NONE) begin
                    n.cmd = i2c_timing_pkg::CMD_NONE;
                end
            end
            default: begin
                if (done) begin
                    n.cnt = '0;
                    unique case (r.phase)
                        i2c_timing_pkg::START_SETUP: begin
                            n.sda_oe = 1'b1;
                            n.phase  = i2c_timing_pkg::START_HOLD;
                        end
                        i2c_timing_pkg::START_HOLD: begin
                            n.scl_oe = 1'b1;
                            n.phase  = i2c_timing_pkg::HOLD;
                        end
                        i2c_timing_pkg::LOW: begin
                            n.scl_oe = 1'b0;
                            n.phase  = i2c_timing_pkg::HIGH;
                        end
                        i2c_timing_pkg::HIGH: begin
                            n.rx_bit = sda_in;        // sample at end of high
                            n.scl_oe = 1'b1;
                            n.phase  = i2c_timing_pkg::HOLD;
                        end
                        i2c_timing_pkg::RS_LOW: begin
                            n.scl_oe = 1'b0;
                            n.phase  = i2c_timing_pkg::START_SETUP;
                        end
                        i2c_timing_pkg::STOP_LOW: begin
                            n.scl_oe = 1'b0;
                            n.phase  = i2c_timing_pkg::STOP_SETUP;
                        end
                        i2c_timing_pkg::STOP_SETUP: begin
                            n.sda_oe = 1'b0;
                            n.phase  = i2c_timing_pkg::BUS_FREE;
                        end
                        default: begin
                            n.phase  = i2c_timing_pkg::IDLE;
                        end
                    endcase
                end
            end
        endcase
        n.awready = !n.aw_hold && !n.bvalid;   // readies follow the held state
        n.wready  = !n.w_hold && !n.bvalid;
        n.arready = !n.rvalid;
    end
    // register the state
    always_ff @(posedge clk) begin
        if (reset) begin
            r       <= '0;                            // idle phase, no command, bus released
            r.high  <= `RST_HIGH;
            r.low   <= `RST_LOW;
            r.hold_setup <= `RST_SETUP;
            r.free_extra <= `RST_FREE;
        end else begin
            r <= n;
        end
    end
    assign s_axi_awready = r.awready;
    assign s_axi_wready  = r.wready;
    assign s_axi_bvalid  = r.bvalid;
    assign s_axi_bresp   = r.bresp;
    assign s_axi_arready = r.arready;
    assign s_axi_rvalid  = r.rvalid;
    assign s_axi_rresp   = r.rresp;
    assign s_axi_rdata   = r.rdata;
    assign scl_oe        = r.scl_oe;
    assign sda_oe        = r.sda_oe;
    // checks on phase lengths and pin ordering
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence leave_s(i2c_timing_pkg::phase_t p);
        r.phase == p && n.phase != p;
    endsequence
    high_len_a: assert property (leave_s(i2c_timing_pkg::HIGH) |->
        r.cnt == {1'b0, r.sh_high} + `ADD_HIGH - 17'h00001) else $error("scl high length wrong");
    low_len_a: assert property (leave_s(i2c_timing_pkg::LOW) |->
        r.cnt == {1'b0, r.sh_low} + `ADD_LOW - 17'h00001) else $error("scl low length wrong");
    start_hold_a: assert property (leave_s(i2c_timing_pkg::START_HOLD) |->
        r.cnt == {1'b0, r.sh_hold_setup}) else $error("start hold length wrong");
    rs_setup_a: assert property (leave_s(i2c_timing_pkg::START_SETUP) |->
        r.cnt == {1'b0, r.sh_hold_setup} ##1 r.sda_oe && !r.scl_oe)
        else $error("restart setup wrong");
    stop_setup_a: assert property (leave_s(i2c_timing_pkg::STOP_SETUP) |->
        r.cnt == {1'b0, r.sh_high} + 17'h00004 ##1 !r.sda_oe) else $error("stop setup wrong");
    bus_free_a: assert property (leave_s(i2c_timing_pkg::BUS_FREE) |->
        r.cnt == {2'b00, r.sh_high[CW-1:1]} + {1'b0, r.sh_free_extra} + 17'h00001)
        else $error("bus free length wrong");
    sda_quiet_a: assert property (r.phase == i2c_timing_pkg::HIGH
        && $past(r.phase) == i2c_timing_pkg::HIGH |-> $stable(r.sda_oe) && !r.scl_oe)
        else $error("sda moved while scl high");
    shadow_hold_a: assert property (r.phase != i2c_timing_pkg::IDLE
        && $past(r.phase) != i2c_timing_pkg::IDLE && r.phase != i2c_timing_pkg::RS_LOW
        |-> $stable(r.sh_high) && $stable(r.sh_low)) else $error("counts changed mid transfer");
    start_form_a: assert property (leave_s(i2c_timing_pkg::IDLE)
        |=> r.sda_oe && !r.scl_oe ##1 !r.scl_oe) else $error("start not formed with scl high");
endmodule

// file: inc/i2c_timing_cfg.svh
// Purpose: offsets, field positions, reset values and timing counts of the scl timing engine
// Assumes: included by bare name; definitions only
// Notes:   count registers hold raw programmed values, phase lengths add fixed extras
`ifndef I2C_TIMING_CFG_SVH
`define I2C_TIMING_CFG_SVH
// register byte offsets
`define OFF_CMD        8'h00
`define OFF_STATUS     8'h04
`define OFF_HIGH       8'h08
`define OFF_LOW        8'h0c
`define OFF_SETUP      8'h10
`define OFF_FREE       8'h14
// command register fields
`define CMD_LSB        0
`define CMD_MSB        2
`define CMD_BIT_POS    8
// status register fields
`define ST_BUSY_POS    0
`define ST_RX_POS      1
`define ST_HELD_POS    2
`define ST_ERR_POS     3
`define ST_PEND_POS    4
// system clock period in ns, phases are counted in its cycles
`define SYS_CLK_NS     16
// reset counts: (high + low) * 16 ns = 10 us, i.e. 100 kHz scl while loading
`define RST_HIGH       16'h0136
`define RST_LOW        16'h013b
`define RST_SETUP      16'h0136
`define RST_FREE       16'h0136
// fixed extras added to each programmed count
`define ADD_HIGH       17'h00005
`define ADD_LOW        17'h00002
`define ADD_SETUP      17'h00001
`define ADD_FREE       17'h00002
// axi answers
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`endif

// file: inc/i2c_timing_pkg.sv
// Purpose: types of the scl timing engine
// Assumes: nothing
// Notes:   numbers live in i2c_timing_cfg.svh
package i2c_timing_pkg;
    // bus phase
    typedef enum logic [3:0] {
        IDLE, START_SETUP, START_HOLD, HOLD, LOW, HIGH,
        RS_LOW, STOP_LOW, STOP_SETUP, BUS_FREE
    } phase_t;
    // software command codes
    typedef enum logic [2:0] {
        CMD_NONE  = 3'h0,
        CMD_START = 3'h1,
        CMD_STOP  = 3'h2,
        CMD_WRITE = 3'h3,
        CMD_READ  = 3'h4
    } cmd_t;
endpackage

// file: verification/i2c_slave_model.sv
// Purpose: i2c slave stand-in that answers the first bit slot of every transfer with a low
// Assumes: scl and sda are the resolved open-drain wires, pulled up when released
// Notes:   sda only moves on a falling scl, so it never forms a false start or stop
`timescale 1ns/10ps
module i2c_slave_model (
    input  wire logic scl,      // resolved clock line
    input  wire logic sda,      // resolved data line
    output logic      sda_pull  // high pulls sda low
);
    logic active;               // between a start and a stop
    int   falls;                // scl falling edges since the last start
    // bus starts released
    initial begin
        active = 1'b0;
        falls = 0;
        sda_pull = 1'b0;
    end
    // start or repeated start: sda falls while scl is high
    always @(negedge sda) begin
        if (scl === 1'b1) begin
            active = 1'b1;
            falls = 0;
        end
    end
    // stop: sda rises while scl is high
    always @(posedge sda) begin
        if (scl === 1'b1) begin
            active = 1'b0;
        end
    end
    // pull low through the first bit slot, let go at the next falling scl
    always @(negedge scl) begin
        sda_pull <= active && (falls == 0);
        falls = falls + 1;
    end
endmodule

// file: verification/i2c_master_scl_timing_bench.sv
// Purpose: self-checking bench for the scl timing engine, registers over axi4-lite
// Assumes: counts high 4, low 6, start setup 3, free extra 2 are written before traffic
// Notes:   a monitor logs every run of {scl_oe, sda_oe}; length 0 in the table means any
`timescale 1ns/10ps
`include "i2c_timing_cfg.svh"
module i2c_master_scl_timing_bench;
    typedef struct packed {
        logic        we;    // write before the read
        logic [7:0]  addr;  // byte address
        logic [31:0] wdata; // written word
        logic [31:0] rdata; // expected read word
        logic [1:0]  resp;  // expected bresp and rresp
    } row_t;
    // register rows: reset values, writes with readback, an unmapped word
    row_t rows [9] = '{
        '{1'b0, `OFF_HIGH, 32'h0, 32'h136, 2'h0}, '{1'b0, `OFF_LOW, 32'h0, 32'h13b, 2'h0},
        '{1'b0, `OFF_SETUP, 32'h0, 32'h136, 2'h0}, '{1'b0, `OFF_FREE, 32'h0, 32'h136, 2'h0},
        '{1'b1, `OFF_HIGH, 32'hffff0004, 32'h4, 2'h0}, '{1'b1, `OFF_LOW, 32'h6, 32'h6, 2'h0},
        '{1'b1, `OFF_SETUP, 32'h3, 32'h3, 2'h0}, '{1'b1, `OFF_FREE, 32'h2, 32'h2, 2'h0},
        '{1'b1, 8'h18, 32'h5, 32'h0, 2'h2}};
    // expected runs {scl_oe, sda_oe, length}: high 9, low 8, start 4,
    // bus free 6 plus the one idle cycle that takes the start queued during the stop
    logic [17:0] exp_run [20] = '{18'h00000, 18'h10004, 18'h30000, 18'h20008, 18'h00009,
        18'h20000, 18'h30008, 18'h10009, 18'h30000, 18'h20008, 18'h00004, 18'h10004,
        18'h30000, 18'h20008, 18'h00009, 18'h20000, 18'h30008, 18'h10009, 18'h00007, 18'h10004};
    logic        clk = 1'b0, reset = 1'b1;                 // clock and reset
    logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0; // addresses
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;         // data
    logic [3:0]  s_axi_wstrb = 4'hf;                       // whole words only
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;           // answers
    logic        scl_oe, sda_oe, slave_pull;               // pin drives
    wire         scl_wire = ~scl_oe;                       // open drain, pulled up
    wire         sda_wire = ~(sda_oe | slave_pull);        // open drain, pulled up
    logic [31:0] data;                                     // read word
    logic [1:0]  pair_q;                                   // pin pair of the current run
    logic [15:0] run_len;                                  // cycles in the current run
    logic [17:0] runs [$];                                 // finished runs
    int          bad_count = 0, samples_checked = 0;       // verdict counters
    always #5 clk = ~clk;
    i2c_master_scl_timing uut (.clk(clk), .reset(reset), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .sda_in(sda_wire), .scl_oe(scl_oe), .sda_oe(sda_oe));
    i2c_slave_model peer (.scl(scl_wire), .sda(sda_wire), .sda_pull(slave_pull));
    // run-length monitor of the pin pair
    always @(posedge clk) begin
        if (reset) begin
            pair_q <= 2'h0;
            run_len <= 16'h0;
        end else if ({scl_oe, sda_oe} === pair_q) begin
            run_len <= run_len + 16'h1;
        end else begin
            runs.push_back({pair_q, run_len});
            pair_q <= {scl_oe, sda_oe};
            run_len <= 16'h1;
        end
    end
    // counts and ends the run
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // one comparison
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // write word: aw and w offered together, each dropped when taken
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_go, w_go, b_go, aw_hit, w_hit, b_hit;
        int   n;
        aw_go = 1'b1;
        w_go = 1'b1;
        b_go = 1'b1;
        n = 0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (b_go && n < 100) begin
            @(negedge clk);
            n++;
            aw_hit = aw_go && (s_axi_awready === 1'b1);
            w_hit = w_go && (s_axi_wready === 1'b1);
            b_hit = (s_axi_bvalid === 1'b1);
            if (b_hit) r = s_axi_bresp;
            @(posedge clk);
            if (aw_hit) begin
                s_axi_awvalid <= 1'b0;
                aw_go = 1'b0;
            end
            if (w_hit) begin
                s_axi_wvalid <= 1'b0;
                w_go = 1'b0;
            end
            if (b_hit) begin
                s_axi_bready <= 1'b0;
                b_go = 1'b0;
            end
        end
        if (b_go) begin
            bad_count++;
            print_verdict();
        end
    endtask
    // read word: address held until taken, rready until rvalid
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_go, r_go, ar_hit, r_hit;
        int   n;
        ar_go = 1'b1;
        r_go = 1'b1;
        n = 0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (r_go && n < 100) begin
            @(negedge clk);
            n++;
            ar_hit = ar_go && (s_axi_arready === 1'b1);
            r_hit = (s_axi_rvalid === 1'b1);
            if (r_hit) d = s_axi_rdata;
            if (r_hit) r = s_axi_rresp;
            @(posedge clk);
            if (ar_hit) begin
                s_axi_arvalid <= 1'b0;
                ar_go = 1'b0;
            end
            if (r_hit) begin
                s_axi_rready <= 1'b0;
                r_go = 1'b0;
            end
        end
        if (r_go) begin
            bad_count++;
            print_verdict();
        end
    endtask
    // issue a command, then, when wait_hold is set, wait until the engine holds scl low for the next one
    task automatic cmd(input logic [31:0] c, input logic wait_hold);
        logic [31:0] st;
        logic [1:0]  r;
        int          n;
        axi_write(`OFF_CMD, c, r);
        check("cmd bresp", 32'(`RESP_OKAY), 32'(r));
        st = 32'h0;
        for (n = 0; wait_hold && st[`ST_HELD_POS] !== 1'b1; n++) begin
            if (n == 60) begin
                bad_count++;
                print_verdict();
            end
            axi_read(`OFF_STATUS, st, r);
        end
    endtask
    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].we) axi_write(rows[i].addr, rows[i].wdata, resp);
            if (rows[i].we) check("bresp", 32'(rows[i].resp), 32'(resp));
            axi_read(rows[i].addr, data, resp);
            check("rdata", rows[i].rdata, data);
            check("rresp", 32'(rows[i].resp), 32'(resp));
        end
        $display("register rows done");
        cmd(32'(i2c_timing_pkg::CMD_STOP), 1'b0);
        axi_read(`OFF_STATUS, data, resp);
        check("err after idle stop", 32'h1, 32'(data[`ST_ERR_POS]));
        axi_write(`OFF_STATUS, 32'h1 << `ST_ERR_POS, resp);
        axi_read(`OFF_STATUS, data, resp);
        check("err after clear", 32'h0, 32'(data[`ST_ERR_POS]));
        $display("refused command done");
        cmd(32'(i2c_timing_pkg::CMD_START), 1'b1);
        cmd(32'(i2c_timing_pkg::CMD_WRITE) | 32'h100, 1'b1);
        cmd(32'(i2c_timing_pkg::CMD_WRITE), 1'b1);
        cmd(32'(i2c_timing_pkg::CMD_START), 1'b1);
        cmd(32'(i2c_timing_pkg::CMD_READ), 1'b1);
        axi_read(`OFF_STATUS, data, resp);
        check("rx bit", 32'h0, 32'(data[`ST_RX_POS]));
        cmd(32'(i2c_timing_pkg::CMD_STOP), 1'b0);
        cmd(32'(i2c_timing_pkg::CMD_START), 1'b1);
        check("run count", 32'd20, 32'(runs.size()));
        for (int i = 0; i < 20 && i < runs.size(); i++) begin
            check($sformatf("pins of run %0d", i), 32'(exp_run[i][17:16]), 32'(runs[i][17:16]));
            if (exp_run[i][15:0] != 16'h0) check($sformatf("length of run %0d", i),
                32'(exp_run[i][15:0]), 32'(runs[i][15:0]));
        end
        $display("transfer timing done");
        print_verdict();
    end
endmodule
